// File: rtl/fsc_frame_sequence_control.v
// Frame sequence control: slot table, slot stepping and frame counting for capture.
// Assumes frame_done pulses from the capture engine on clk; trigger_in is a pin.
`timescale 1ns/1ps
`include "fsc_map.vh"

module fsc_frame_sequence_control (
  input wire clk,
  input wire reset_n,
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  input wire trigger_in,
  input wire frame_done,
  output reg frame_request,
  output reg acquiring,
  output reg sequence_active,
  output reg [3:0] active_slot,
  output reg [3:0] saved_profile
);

  // Slot table: entry 0..15 holds slots 1..16, each entry written by its own process
  reg [3:0] step_profile_number [0:`FSC_SLOTS-1];

  // Host settings
  reg [4:0] step_slot_select_r;
  reg [4:0] sequence_length_r;
  reg sequence_run_enable_r;
  reg sequence_run_enable_d_r;
  reg capture_mode_select_r;
  reg trigger_gate_select_r;
  reg [2:0] trigger_scheme_select_r;
  reg [15:0] transfer_frame_limit_r;
  reg [15:0] burst_frame_count_r;

  // Run state and counters
  reg [15:0] frames_done_r;
  reg [15:0] burst_left_r;
  reg [1:0] run_state_r;
  reg [1:0] run_state_nxt;

  // Pin synchroniser
  reg trig_s1_r;
  reg trig_s2_r;
  reg trig_s3_r;

  // Next values
  reg [15:0] rdata_nxt;
  reg [3:0] slot_ptr_nxt;
  reg [3:0] profile_nxt;
  reg frame_request_nxt;
  reg [15:0] frames_done_nxt;
  reg [15:0] burst_left_nxt;

  // Decodes
  wire trig_edge;
  wire start_wr;
  wire seq_rise;
  wire limit_hit;
  wire frame_issue;
  wire slot_prof_wr;
  wire [4:0] slot_idx;
  wire [4:0] slot_inc;
  wire burst_scheme;
  wire [15:0] status_word;
  wire [`FSC_SLOTS-1:0] entry_wr;
  genvar g;

  // Acquisition states; arm means allowed to ask for the next frame
  localparam [1:0] RUN_IDLE = 2'b00;
  localparam [1:0] RUN_ARM = 2'b01;
  localparam [1:0] RUN_WAIT = 2'b10;

  // Two flops before any logic looks at the pin; third flop is edge history
  assign trig_edge = trig_s2_r & ~trig_s3_r;
  assign start_wr = reg_wr && (reg_addr == `FSC_A_START);
  assign seq_rise = sequence_run_enable_r & ~sequence_run_enable_d_r;
  assign burst_scheme = trigger_gate_select_r && (trigger_scheme_select_r == `FSC_SCHEME_BURST);
  // Counted capture caps all modes at the transfer limit, burst included
  assign limit_hit = (capture_mode_select_r == `FSC_MODE_COUNTED)
                     && (frames_done_r + `FSC_CNT_ONE >= transfer_frame_limit_r);
  assign slot_idx = step_slot_select_r - `FSC_SLOT_MIN;
  // Wrap after the programmed length
  assign slot_inc = {1'b0, active_slot} + `FSC_SLOT_MIN;
  assign slot_prof_wr = reg_wr && (reg_addr == `FSC_A_SLOT_PROF)
                        && (reg_wdata[3:0] >= `FSC_PROF_MIN) && (reg_wdata[15:4] == 12'h000);
  // A frame may be asked for untriggered, mid-burst, or on a fresh trigger edge
  assign frame_issue = !trigger_gate_select_r || (burst_left_r != `FSC_CNT_ZERO) || trig_edge;
  assign status_word = {4'h0, saved_profile, active_slot, 2'h0, acquiring, sequence_active};

  // One write decode and one holding register per slot entry
  generate
    for (g = 0; g < `FSC_SLOTS; g = g + 1)
    begin : g_entry
      localparam [4:0] ENTRY_IDX = g;
      assign entry_wr[g] = slot_prof_wr && (slot_idx == ENTRY_IDX);
      always @(posedge clk)
      begin
        if (!reset_n)
          step_profile_number[g] <= `FSC_PROF_MIN;
        else if (entry_wr[g])
          step_profile_number[g] <= reg_wdata[3:0];
      end
    end
  endgenerate

  always @(posedge clk)
  begin
    trig_s1_r <= trigger_in;
    trig_s2_r <= trig_s1_r;
    trig_s3_r <= trig_s2_r;
  end

  // Register writes; out-of-range values are ignored, keeping the old value
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      step_slot_select_r <= `FSC_SLOT_MIN;
      sequence_length_r <= `FSC_LEN_RST;
      sequence_run_enable_r <= 1'b0;
      capture_mode_select_r <= `FSC_MODE_CONT;
      trigger_gate_select_r <= 1'b0;
      trigger_scheme_select_r <= `FSC_SCHEME_SINGLE;
      transfer_frame_limit_r <= `FSC_CNT_ONE;
      burst_frame_count_r <= `FSC_CNT_ONE;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `FSC_A_SLOT_SEL:
          if (reg_wdata[4:0] >= `FSC_SLOT_MIN && reg_wdata[4:0] <= `FSC_SLOT_MAX
              && reg_wdata[15:5] == 11'h000)
            step_slot_select_r <= reg_wdata[4:0];
        `FSC_A_SEQ_LEN:
          if (reg_wdata[4:0] >= `FSC_SLOT_MIN && reg_wdata[4:0] <= `FSC_SLOT_MAX
              && reg_wdata[15:5] == 11'h000)
            sequence_length_r <= reg_wdata[4:0];
        `FSC_A_SEQ_EN: sequence_run_enable_r <= reg_wdata[0];
        `FSC_A_CAP_MODE: capture_mode_select_r <= reg_wdata[0];
        `FSC_A_TRIG_GATE: trigger_gate_select_r <= reg_wdata[0];
        `FSC_A_TRIG_SCHEME: trigger_scheme_select_r <= reg_wdata[2:0];
        `FSC_A_FRM_LIMIT:
          if (reg_wdata != `FSC_CNT_ZERO)
            transfer_frame_limit_r <= reg_wdata;
        `FSC_A_BURST_CNT:
          if (reg_wdata != `FSC_CNT_ZERO)
            burst_frame_count_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Read port: data valid the cycle after the strobe, zero for unmapped
  always @*
  begin
    rdata_nxt = `FSC_CNT_ZERO;
    if (reg_rd)
    begin
      case (reg_addr)
        `FSC_A_SLOT_SEL: rdata_nxt = {11'h000, step_slot_select_r};
        `FSC_A_SLOT_PROF: rdata_nxt = {12'h000, step_profile_number[slot_idx[3:0]]};
        `FSC_A_SEQ_LEN: rdata_nxt = {11'h000, sequence_length_r};
        `FSC_A_SEQ_EN: rdata_nxt = {15'h0000, sequence_run_enable_r};
        `FSC_A_CAP_MODE: rdata_nxt = {15'h0000, capture_mode_select_r};
        `FSC_A_TRIG_GATE: rdata_nxt = {15'h0000, trigger_gate_select_r};
        `FSC_A_TRIG_SCHEME: rdata_nxt = {13'h0000, trigger_scheme_select_r};
        `FSC_A_FRM_LIMIT: rdata_nxt = transfer_frame_limit_r;
        `FSC_A_BURST_CNT: rdata_nxt = burst_frame_count_r;
        `FSC_A_STATUS: rdata_nxt = status_word;
        `FSC_A_FRM_DONE: rdata_nxt = frames_done_r;
        default: rdata_nxt = `FSC_CNT_ZERO;
      endcase
    end
  end

  // Cleared when no read is under way, so stale data never lingers on the bus
  always @(posedge clk)
  begin
    if (!reset_n)
      reg_rdata <= `FSC_CNT_ZERO;
    else
      reg_rdata <= rdata_nxt;
  end

  // Next slot pointer; a rising run enable beats a finished frame in the same cycle
  always @*
  begin
    slot_ptr_nxt = active_slot;
    if (seq_rise)
      slot_ptr_nxt = `FSC_SLOT_FIRST;
    else if (sequence_run_enable_r && frame_done)
    begin
      if (slot_inc >= sequence_length_r)
        slot_ptr_nxt = `FSC_SLOT_FIRST;
      else
        slot_ptr_nxt = slot_inc[3:0];
    end
  end

  // Profile follows the slot that the next capture uses
  always @*
  begin
    profile_nxt = saved_profile;
    if (sequence_run_enable_r)
      profile_nxt = step_profile_number[slot_ptr_nxt];
  end

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      sequence_run_enable_d_r <= 1'b0;
      sequence_active <= 1'b0;
      active_slot <= `FSC_SLOT_FIRST;
    end
    else
    begin
      sequence_run_enable_d_r <= sequence_run_enable_r;
      sequence_active <= sequence_run_enable_r;
      active_slot <= slot_ptr_nxt;
    end
  end

  always @(posedge clk)
  begin
    if (!reset_n)
      saved_profile <= `FSC_PROF_MIN;
    else
      saved_profile <= profile_nxt;
  end

  // Acquisition sequencing. Settings are read live every cycle, mid-acquisition too: change them while idle.
  always @*
  begin
    run_state_nxt = run_state_r;
    frame_request_nxt = 1'b0;
    case (run_state_r)
      RUN_IDLE:
        run_state_nxt = RUN_IDLE;
      RUN_ARM:
        if (frame_issue)
        begin
          frame_request_nxt = 1'b1;
          run_state_nxt = RUN_WAIT;
        end
      RUN_WAIT:
        if (frame_done)
        begin
          if (limit_hit)
            run_state_nxt = RUN_IDLE;
          else
            run_state_nxt = RUN_ARM;
        end
      default:
        run_state_nxt = RUN_IDLE;
    endcase
    // A start or stop write wins over anything the engine reports in that cycle
    if (start_wr)
    begin
      run_state_nxt = reg_wdata[0] ? RUN_ARM : RUN_IDLE;
      frame_request_nxt = 1'b0;
    end
  end

  // Frames finished since the last start; the transfer limit is held against this
  always @*
  begin
    frames_done_nxt = frames_done_r;
    if (start_wr)
      frames_done_nxt = `FSC_CNT_ZERO;
    else if ((run_state_r == RUN_WAIT) && frame_done)
      frames_done_nxt = frames_done_r + `FSC_CNT_ONE;
  end

  // Frames still owed to the current burst; a trigger that lands mid-burst is ignored
  always @*
  begin
    burst_left_nxt = burst_left_r;
    if (start_wr)
      burst_left_nxt = `FSC_CNT_ZERO;
    else if ((run_state_r == RUN_ARM) && frame_issue && trigger_gate_select_r)
    begin
      if (burst_left_r != `FSC_CNT_ZERO)
        burst_left_nxt = burst_left_r - `FSC_CNT_ONE;
      else if (burst_scheme)
        burst_left_nxt = burst_frame_count_r - `FSC_CNT_ONE;
    end
    else if ((run_state_r == RUN_WAIT) && frame_done && limit_hit)
      burst_left_nxt = `FSC_CNT_ZERO;
  end

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      run_state_r <= RUN_IDLE;
      acquiring <= 1'b0;
      frame_request <= 1'b0;
    end
    else
    begin
      run_state_r <= run_state_nxt;
      acquiring <= (run_state_nxt != RUN_IDLE);
      frame_request <= frame_request_nxt;
    end
  end

  always @(posedge clk)
  begin
    if (!reset_n)
      frames_done_r <= `FSC_CNT_ZERO;
    else
      frames_done_r <= frames_done_nxt;
  end

  always @(posedge clk)
  begin
    if (!reset_n)
      burst_left_r <= `FSC_CNT_ZERO;
    else
      burst_left_r <= burst_left_nxt;
  end

endmodule // fsc_frame_sequence_control

// File: include/fsc_map.vh
// Register offsets, field layouts, reset values and codes for the sequencing block.
// Assumes a plain one-cycle register port with read data one cycle after the read strobe.
`ifndef FSC_MAP_VH
`define FSC_MAP_VH

// Register word offsets
`define FSC_A_SLOT_SEL 4'h0
`define FSC_A_SLOT_PROF 4'h1
`define FSC_A_SEQ_LEN 4'h2
`define FSC_A_SEQ_EN 4'h3
`define FSC_A_CAP_MODE 4'h4
`define FSC_A_FRM_LIMIT 4'h5
`define FSC_A_TRIG_GATE 4'h6
`define FSC_A_TRIG_SCHEME 4'h7
`define FSC_A_BURST_CNT 4'h8
`define FSC_A_STATUS 4'h9
`define FSC_A_FRM_DONE 4'hA
`define FSC_A_START 4'hB

// Slot and profile limits
`define FSC_SLOT_MIN 5'h01
`define FSC_SLOT_MAX 5'h10
`define FSC_PROF_MIN 4'h1
`define FSC_PROF_MAX 4'hF
`define FSC_LEN_RST 5'h01
`define FSC_SLOTS 16
`define FSC_SLOT_FIRST 4'h0

// Capture modes and trigger schemes
`define FSC_MODE_CONT 1'b0
`define FSC_MODE_COUNTED 1'b1
`define FSC_SCHEME_SINGLE 3'h0
`define FSC_SCHEME_BURST 3'h6

// Counter widths and resets
`define FSC_CNT_W 16
`define FSC_CNT_ONE 16'h0001
`define FSC_CNT_ZERO 16'h0000

// Status bit positions
`define FSC_ST_RUN 0
`define FSC_ST_BUSY 1
`define FSC_ST_PTR_LO 4
`define FSC_ST_PTR_HI 7
`define FSC_ST_PROF_LO 8
`define FSC_ST_PROF_HI 11

`endif

// File: verification/fsc_frame_sequence_control_assertions.sv
// Port checker for the frame sequence control block.
// Assumes one clock domain and a bind onto the top module.
`timescale 1ns/1ps
module fsc_chk (
  input logic clk,
  input logic reset_n,
  input logic reg_wr,
  input logic frame_done,
  input logic frame_request,
  input logic acquiring,
  input logic sequence_active,
  input logic [3:0] active_slot,
  input logic [3:0] saved_profile
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  req_pulse_a: assert property (frame_request |=> !frame_request)
    else $error("frame request longer than one cycle");
  req_acq_a: assert property (frame_request |-> acquiring)
    else $error("frame request while idle");
  acq_stop_a: assert property ($fell(acquiring) |-> $past(frame_done) || $past(reg_wr))
    else $error("acquisition stopped without cause");
  acq_start_a: assert property ($rose(acquiring) |-> $past(reg_wr))
    else $error("acquisition started without write");
  seq_start_a: assert property ($rose(sequence_active) |-> active_slot == 4'h0)
    else $error("sequence did not restart at slot one");
  slot_step_a: assert property ($changed(active_slot) |->
    active_slot == $past(active_slot) + 4'h1 || active_slot == 4'h0)
    else $error("slot pointer jumped");
  slot_hold_a: assert property ($past(sequence_active) && !$past(frame_done) |->
    $stable(active_slot))
    else $error("slot moved without a finished frame");
  prof_range_a: assert property (saved_profile != 4'h0)
    else $error("profile number zero");
endmodule // fsc_chk
bind fsc_frame_sequence_control fsc_chk u_chk (.clk(clk), .reset_n(reset_n), .reg_wr(reg_wr),
  .frame_done(frame_done), .frame_request(frame_request), .acquiring(acquiring),
  .sequence_active(sequence_active), .active_slot(active_slot), .saved_profile(saved_profile));

// File: verification/fsc_engine_model.sv
// Capture engine model: answers each frame request with one frame_done pulse.
// Assumes one outstanding request; slow stretches the answer.
`timescale 1ns/1ps
module fsc_engine_model (
  input logic clk,
  input logic reset_n,
  input logic frame_request,
  input logic slow,
  output logic frame_done
);
  logic [3:0] cnt_r;
  always @(posedge clk)
  begin
    frame_done <= reset_n && cnt_r == 4'h1;
    if (!reset_n)
      cnt_r <= 4'h0;
    else if (frame_request)
      cnt_r <= slow ? 4'hC : 4'h3;
    else if (cnt_r != 4'h0)
      cnt_r <= cnt_r - 4'h1;
  end
endmodule // fsc_engine_model

// File: verification/frame_sequence_control_bench.sv
// Bench for frame sequence control: register tasks, engine model, trigger pulses.
// Assumes read data stand only in the cycle after the read strobe.
`timescale 1ns/1ps
`include "fsc_map.vh"
module frame_sequence_control_bench;
  logic clk, reset_n, reg_wr, reg_rd, trigger_in, slow;
  logic frame_done, frame_request, acquiring, sequence_active;
  logic [3:0] reg_addr, active_slot, saved_profile;
  logic [15:0] reg_wdata, reg_rdata;
  int miscompares = 0, num_checks = 0, n_req = 0, i;
  fsc_frame_sequence_control dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .trigger_in(trigger_in), .frame_done(frame_done), .frame_request(frame_request),
    .acquiring(acquiring), .sequence_active(sequence_active), .active_slot(active_slot),
    .saved_profile(saved_profile));
  fsc_engine_model eng (.clk(clk), .reset_n(reset_n), .frame_request(frame_request),
    .slow(slow), .frame_done(frame_done));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
    if (frame_request === 1'b1)
      n_req <= n_req + 1;
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk("rdata", e, reg_rdata);
  endtask
  // Bounded wait: sel 0 for a finished frame, 1 for acquisition idle
  task automatic wait_for(int sel);
    @(negedge clk);
    for (int k = 0; k < 400 && (sel ? acquiring !== 1'b0 : frame_done !== 1'b1); k++)
      @(negedge clk);
  endtask
  // Held for several cycles so the pin synchroniser sees one clean edge
  task automatic trig;
    @(posedge clk);
    trigger_in <= 1'b1;
    repeat (4) @(posedge clk);
    trigger_in <= 1'b0;
    repeat (40) @(posedge clk);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    {reset_n, reg_wr, reg_rd, trigger_in, slow} = 5'h00;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    for (i = 0; i < 9; i++)
      rd(i[3:0], (i inside {3, 4, 6, 7}) ? 16'h0000 : 16'h0001);
    rd(4'hC, 16'h0000);
    wr(`FSC_A_SLOT_SEL, 16'h0011);
    wr(`FSC_A_SLOT_SEL, 16'h0000);
    rd(`FSC_A_SLOT_SEL, 16'h0001);
    wr(`FSC_A_SLOT_SEL, 16'h0010);
    rd(`FSC_A_SLOT_SEL, 16'h0010);
    wr(`FSC_A_SLOT_PROF, 16'h0010);
    rd(`FSC_A_SLOT_PROF, 16'h0001);
    wr(`FSC_A_SLOT_PROF, 16'h000F);
    rd(`FSC_A_SLOT_PROF, 16'h000F);
    for (i = 1; i < 4; i++)
    begin
      wr(`FSC_A_SLOT_SEL, i[15:0]);
      wr(`FSC_A_SLOT_PROF, 16'(i + 4));
    end
    wr(`FSC_A_SEQ_LEN, 16'h0003);
    wr(`FSC_A_SEQ_EN, 16'h0001);
    repeat (2) @(negedge clk);
    chk("slot", 16'h0000, {12'h000, active_slot});
    chk("prof", 16'h0005, {12'h000, saved_profile});
    wr(`FSC_A_START, 16'h0001);
    for (i = 1; i < 8; i++)
    begin
      wait_for(0);
      @(negedge clk);
      chk("slot", 16'(i % 3), {12'h000, active_slot});
      chk("prof", 16'(i % 3 + 5), {12'h000, saved_profile});
    end
    wr(`FSC_A_START, 16'h0000);
    wait_for(0);
    wr(`FSC_A_SEQ_EN, 16'h0000);
    wr(`FSC_A_SEQ_EN, 16'h0001);
    repeat (2) @(negedge clk);
    chk("slot", 16'h0000, {12'h000, active_slot});
    wr(`FSC_A_SEQ_EN, 16'h0000);
    slow <= 1'b1;
    wr(`FSC_A_CAP_MODE, 16'h0001);
    wr(`FSC_A_FRM_LIMIT, 16'h0003);
    n_req <= 0;
    wr(`FSC_A_START, 16'h0001);
    wait_for(1);
    chk("frames", 16'h0003, n_req[15:0]);
    rd(`FSC_A_FRM_DONE, 16'h0003);
    slow <= 1'b0;
    wr(`FSC_A_TRIG_GATE, 16'h0001);
    wr(`FSC_A_FRM_LIMIT, 16'h0002);
    n_req <= 0;
    wr(`FSC_A_START, 16'h0001);
    trig;
    chk("frames", 16'h0001, n_req[15:0]);
    chk("acq", 16'h0001, {15'h0000, acquiring});
    trig;
    chk("frames", 16'h0002, n_req[15:0]);
    chk("acq", 16'h0000, {15'h0000, acquiring});
    wr(`FSC_A_TRIG_SCHEME, 16'h0006);
    wr(`FSC_A_BURST_CNT, 16'h0003);
    wr(`FSC_A_CAP_MODE, 16'h0000);
    n_req <= 0;
    wr(`FSC_A_START, 16'h0001);
    trig;
    chk("frames", 16'h0003, n_req[15:0]);
    wr(`FSC_A_START, 16'h0000);
    wr(`FSC_A_CAP_MODE, 16'h0001);
    n_req <= 0;
    wr(`FSC_A_START, 16'h0001);
    trig;
    chk("frames", 16'h0002, n_req[15:0]);
    chk("acq", 16'h0000, {15'h0000, acquiring});
    final_report;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    final_report;
  end
endmodule // frame_sequence_control_bench
